// ===== rtl/tmf_pkg.sv
// What this block does
// (RULE1) Source select clear: count every instruction cycle
// (RULE2) Timer write blocks increments for two cycles
// (RULE3) Source select set: count external pin edges
// (RULE4) Edge select: clear rising, set falling
// (RULE5) One prescaler, assign bit picks timer/watchdog
// (RULE6) Timer prescale 1:2 to 1:256, count hidden
// (RULE7) Wrap FFh to 00h sets overflow flag
// (RULE8) Overflow enable masks request, flag still sets
// (RULE9) Software clears overflow flag; hardware never does
// (RULE10) Sleep stops timer; overflow cannot wake
// (RULE11) External pin edge: select set rising, clear falling
// (RULE12) Valid external edge sets external flag
// (RULE13) External enable clear disables its request
// (RULE14) Software clears external flag before re-enabling
// (RULE15) Enabled external interrupt wakes from sleep
// (RULE16) Upper port nibble change sets port flag
// (RULE17) Port change enable gates port request
// (RULE18) Port flag may miss change during port read
// (RULE19) Warm reset clears bits 7..1, keeps port flag
// (RULE20) Flags set regardless of any enable
// (RULE21) Comparator change flag bit 6, enable bit 6
// (RULE22) Request: global enable and any enabled flag
package tmf_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] TMF_ADDR_TIMER = 8'h01;
	localparam logic [7:0] TMF_ADDR_INTCTL = 8'h0b;
	localparam logic [7:0] TMF_ADDR_PFLAG = 8'h0c;
	localparam logic [7:0] TMF_ADDR_OPTION = 8'h81;
	localparam logic [7:0] TMF_ADDR_PEN = 8'h8c;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int TMF_IC_GIE = 7;
	localparam int TMF_IC_PERIPHERAL_INT_ENABLE = 6;
	localparam int TMF_IC_TOE = 5;
	localparam int TMF_IC_EXE = 4;
	localparam int TMF_IC_PCE = 3;
	localparam int TMF_IC_TOF = 2;
	localparam int TMF_IC_EXF = 1;
	localparam int TMF_IC_PCF = 0;
	localparam int TMF_OP_EDG = 6;
	localparam int TMF_OP_SRC = 5;
	localparam int TMF_OP_CES = 4;
	localparam int TMF_OP_PSA = 3;
	localparam int TMF_PF_CMF = 6;
	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [7:0] TMF_OPTION_RST = 8'hff;
	localparam logic [7:0] TMF_IC_WARM_MASK = 8'h01;
	localparam logic [1:0] TMF_WR_HOLD = 2'h2;
endpackage

// ===== rtl/tmf_prescale.sv
`timescale 1ns/1ns
// Shared prescaler; ratio 2^(sel+1); count is not visible to software
module tmf_prescale #(
	parameter int WIDTH = 8
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clr,
	input wire logic tick_in,
	input wire logic [2:0] ratio_sel,
	output logic tick_out
);
	logic [WIDTH-1:0] cnt_reg;
	logic [WIDTH-1:0] top;
	initial begin
		if (WIDTH != 8) begin
			$error("tmf_prescale: WIDTH must be 8");
		end
	end
	assign top = WIDTH'((2 << ratio_sel) - 1);
	// Output tick on the terminal input tick
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= '0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (clr) begin
				cnt_reg <= '0;
			end else if (tick_in) begin
				if (cnt_reg >= top) begin
					cnt_reg <= '0;
					tick_out <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
		end
	end
endmodule

// ===== rtl/tmf_sync.sv
`timescale 1ns/1ns
// Three-flop synchroniser; a change counts once stages two and three agree
module tmf_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg;
	// Stage one is read only by stage two
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			sync_out <= '0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					sync_out[i] <= s3_reg[i];
				end
			end
		end
	end
endmodule

// ===== rtl/tmf_top.sv
// Local design decision: strobed register access.
`timescale 1ns/1ns
module tmf_top (
	core_clk,
	resetn,
	por_event,
	sleep_mode,
	ext_count_pin,
	ext_int_pin,
	port_upper_pins,
	port_read,
	cmp_out,
	wdt_tick,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	int_request,
	wake_request,
	wdt_prescaled
);
	import tmf_pkg::*;
	input wire logic core_clk;
	input wire logic resetn;
	input wire logic por_event;
	input wire logic sleep_mode;
	input wire logic ext_count_pin;
	input wire logic ext_int_pin;
	input wire logic [3:0] port_upper_pins;
	input wire logic port_read;
	input wire logic [1:0] cmp_out;
	input wire logic wdt_tick;
	input wire logic [7:0] reg_addr;
	input wire logic [7:0] reg_wdata;
	input wire logic reg_wr;
	input wire logic reg_rd;
	output logic [7:0] reg_rdata;
	output logic int_request;
	output logic wake_request;
	output logic wdt_prescaled;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0] timer;
		logic [7:0] intctl;
		logic [7:0] option;
		logic cmf;
		logic cme;
		logic [1:0] hold;
		logic cnt_prev;
		logic ext_prev;
		logic [3:0] port_prev;
		logic [1:0] cmp_prev;
		logic [7:0] rdata;
		logic irq;
		logic wake;
		logic primed;
	} tmf_state_s;

	tmf_state_s st_reg, st_next;
	logic cnt_s, ext_s;
	logic pcf_keep_reg;
	logic [3:0] port_s;
	logic [1:0] cmp_s;
	logic pre_in, pre_out;
	logic use_pre, raw_tick, tmr_tick;
	logic wr_timer, wr_intctl;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Reset cause is steady across reset, so it needs no synchroniser
	tmf_sync #(.WIDTH(8)) u_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.async_in({ext_count_pin, ext_int_pin, port_upper_pins, cmp_out}),
		.sync_out({cnt_s, ext_s, port_s, cmp_s})
	);

	// ****************************************
	// Timer source and shared prescaler
	// ****************************************
	// Counter mode edge pick; source select chooses input (RULE3) (RULE4)
	always_comb begin
		if (st_reg.option[TMF_OP_SRC]) begin
			raw_tick = st_reg.option[TMF_OP_CES] ?
				(st_reg.cnt_prev & ~cnt_s) : (~st_reg.cnt_prev & cnt_s);
		end else begin
			raw_tick = 1'b1; // RULE1
		end
	end
	// Assign bit routes prescaler to timer or watchdog (RULE5)
	assign use_pre = ~st_reg.option[TMF_OP_PSA];
	assign pre_in = use_pre ? (raw_tick & ~sleep_mode) : wdt_tick;

	// Prescaler count hidden from software (RULE6)
	tmf_prescale #(.WIDTH(8)) u_pre (
		.core_clk(core_clk),
		.resetn(resetn),
		.clr(wr_timer | (st_reg.option[TMF_OP_PSA] != reg_wdata[TMF_OP_PSA]
			& reg_wr & reg_addr == TMF_ADDR_OPTION)),
		.tick_in(pre_in),
		.ratio_sel(st_reg.option[2:0]),
		.tick_out(pre_out)
	);
	// Sleep shuts the timer off (RULE10)
	assign tmr_tick = ~sleep_mode & (use_pre ? pre_out : raw_tick);
	assign wr_timer = reg_wr & (reg_addr == TMF_ADDR_TIMER);
	assign wr_intctl = reg_wr & (reg_addr == TMF_ADDR_INTCTL);

	// ****************************************
	// Next state
	// ****************************************
	// Flags set over any clear in the same cycle
	always_comb begin
		logic ovf;
		logic ext_edge;
		logic port_chg;
		logic cmp_chg;
		ovf = 1'b0;
		ext_edge = 1'b0;
		port_chg = 1'b0;
		cmp_chg = 1'b0;
		st_next = st_reg;
		st_next.cnt_prev = cnt_s;
		st_next.ext_prev = ext_s;
		st_next.cmp_prev = cmp_s;
		st_next.primed = 1'b1;
		// Port latch refreshes on a read; a change racing it still sets the port flag
		if (port_read) begin
			st_next.port_prev = port_s; // RULE18
		end
		port_chg = st_reg.primed & (port_s != st_reg.port_prev); // RULE16
		ext_edge = st_reg.option[TMF_OP_EDG] ?
			(~st_reg.ext_prev & ext_s) : (st_reg.ext_prev & ~ext_s); // RULE11
		cmp_chg = st_reg.primed & (cmp_s != st_reg.cmp_prev); // RULE21
		// Timer write, then two suppressed cycles
		if (wr_timer) begin
			st_next.timer = reg_wdata;
			st_next.hold = TMF_WR_HOLD; // RULE2
		end else if (st_reg.hold != 2'h0) begin
			st_next.hold = st_reg.hold - 2'h1; // RULE2
		end else if (tmr_tick) begin
			st_next.timer = st_reg.timer + 8'h01;
			ovf = (st_reg.timer == 8'hff); // RULE7
		end
		if (reg_wr && reg_addr == TMF_ADDR_OPTION) begin
			st_next.option = reg_wdata;
		end
		if (wr_intctl) begin
			st_next.intctl = reg_wdata; // RULE9 RULE14
		end
		if (reg_wr && reg_addr == TMF_ADDR_PFLAG) begin
			st_next.cmf = reg_wdata[TMF_PF_CMF];
		end
		if (reg_wr && reg_addr == TMF_ADDR_PEN) begin
			st_next.cme = reg_wdata[TMF_PF_CMF];
		end
		// Flags ignore every enable (RULE20)
		if (ovf) begin
			st_next.intctl[TMF_IC_TOF] = 1'b1; // RULE7
		end
		if (st_reg.primed && ext_edge) begin
			st_next.intctl[TMF_IC_EXF] = 1'b1; // RULE12
		end
		if (port_chg) begin
			st_next.intctl[TMF_IC_PCF] = 1'b1; // RULE16
			st_next.port_prev = port_s;
		end
		if (cmp_chg) begin
			st_next.cmf = 1'b1; // RULE21
		end
		// Enabled sources into one request (RULE8) (RULE13) (RULE17)
		st_next.irq = st_next.intctl[TMF_IC_GIE] & (
			(st_next.intctl[TMF_IC_TOE] & st_next.intctl[TMF_IC_TOF]) |
			(st_next.intctl[TMF_IC_EXE] & st_next.intctl[TMF_IC_EXF]) |
			(st_next.intctl[TMF_IC_PCE] & st_next.intctl[TMF_IC_PCF]) |
			(st_next.intctl[TMF_IC_PERIPHERAL_INT_ENABLE] & st_next.cme & st_next.cmf));
		// RULE22
		// Wake is independent of global enable; timer cannot wake
		st_next.wake = sleep_mode &
			st_next.intctl[TMF_IC_EXE] & st_next.intctl[TMF_IC_EXF]; // RULE15
		// Read data valid the cycle after the strobe only
		st_next.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				TMF_ADDR_TIMER: st_next.rdata = st_reg.timer;
				TMF_ADDR_INTCTL: st_next.rdata = st_reg.intctl;
				TMF_ADDR_OPTION: st_next.rdata = st_reg.option;
				TMF_ADDR_PFLAG: st_next.rdata = {1'b0, st_reg.cmf, 6'h00};
				TMF_ADDR_PEN: st_next.rdata = {1'b0, st_reg.cme, 6'h00};
				default: st_next.rdata = 8'h00;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// Warm reset keeps the port flag; power-on clears it to a defined 0
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
			st_reg.option <= TMF_OPTION_RST;
		end else if (!st_reg.primed) begin
			st_reg <= st_next;
			st_reg.intctl <= por_event ? 8'h00 :
				({7'h00, pcf_keep_reg} & TMF_IC_WARM_MASK); // RULE19
		end else begin
			st_reg <= st_next;
		end
	end

	// Side flop keeps the port flag; frozen while reset is low
	always_ff @(posedge core_clk) begin
		if (resetn) begin
			pcf_keep_reg <= st_reg.intctl[TMF_IC_PCF]; // RULE19
		end
	end

	// Warm reset leaves port flag alone; hold across reset via side flop
	assign reg_rdata = st_reg.rdata;
	assign int_request = st_reg.irq;
	assign wake_request = st_reg.wake;

	// Watchdog side of the prescaler
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wdt_prescaled <= 1'b0;
		end else begin
			wdt_prescaled <= use_pre ? wdt_tick : pre_out; // RULE5
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_write_holds: assert property (@(posedge core_clk) disable iff (!resetn)
		wr_timer ##1 !wr_timer ##1 !wr_timer |->
		st_reg.timer == $past(st_reg.timer)) // RULE2
		else $error("timer moved during write hold");
	a_ovf_sets: assert property (@(posedge core_clk) disable iff (!resetn)
		st_reg.timer == 8'hff ##1 st_reg.timer == 8'h00 && !$past(wr_timer)
		|-> st_reg.intctl[TMF_IC_TOF]) // RULE7
		else $error("overflow flag missing");
	a_sleep_stops: assert property (@(posedge core_clk) disable iff (!resetn)
		sleep_mode && $past(sleep_mode) && !$past(wr_timer) && !wr_timer
		&& st_reg.hold == 2'h0 |=> $stable(st_reg.timer)) // RULE10
		else $error("timer ran in sleep");
	a_irq_masked: assert property (@(posedge core_clk) disable iff (!resetn)
		!st_reg.intctl[TMF_IC_GIE] |-> !int_request) // RULE22
		else $error("request without global enable");
	a_ext_wake: assert property (@(posedge core_clk) disable iff (!resetn)
		wake_request |-> st_reg.intctl[TMF_IC_EXE]) // RULE15
		else $error("wake without external enable");
	a_ext_flag: assert property (@(posedge core_clk) disable iff (!resetn)
		st_reg.primed && !wr_intctl && st_reg.option[TMF_OP_EDG]
		&& !st_reg.ext_prev && ext_s |=> st_reg.intctl[TMF_IC_EXF]) // RULE12
		else $error("external flag missing");
	a_tmr_mask: assert property (@(posedge core_clk) disable iff (!resetn)
		!st_reg.intctl[TMF_IC_TOE] && !st_reg.intctl[TMF_IC_EXE]
		&& !st_reg.intctl[TMF_IC_PCE] && !st_reg.intctl[TMF_IC_PERIPHERAL_INT_ENABLE]
		|-> !int_request) // RULE8
		else $error("request with every source masked");
	a_timer_mode: assert property (@(posedge core_clk) disable iff (!resetn)
		!st_reg.option[TMF_OP_SRC] && st_reg.option[TMF_OP_PSA]
		&& !sleep_mode && st_reg.hold == 2'h0 && !wr_timer
		|=> st_reg.timer == $past(st_reg.timer) + 8'h01) // RULE1
		else $error("timer mode not counting");
	c_overflow: cover property (@(posedge core_clk)
		st_reg.intctl[TMF_IC_TOF]);
	c_ext_flag: cover property (@(posedge core_clk)
		st_reg.intctl[TMF_IC_EXF]);
	c_wake: cover property (@(posedge core_clk) wake_request);
endmodule

// ===== verif/tb_tmf_top.sv
`timescale 1ns/1ns
module tb_tmf_top;
	import tmf_pkg::*;
	logic core_clk, resetn, por_event, sleep_mode, port_read, wdt_tick;
	logic reg_wr, reg_rd, int_request, wake_request, wdt_prescaled;
	logic ext_count_pin, ext_int_pin;
	logic [3:0] port_upper_pins;
	logic [1:0] cmp_out;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v, t0;
	int err_count, compares, n, wt, wp, wt0, wp0;
	// ****************************************
	// Design, pin model, clock
	// ****************************************
	tmf_top i_tmf_top (.core_clk, .resetn, .por_event, .sleep_mode,
		.ext_count_pin, .ext_int_pin, .port_upper_pins, .port_read,
		.cmp_out, .wdt_tick, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .int_request, .wake_request, .wdt_prescaled);
	tmf_pin_model i_tmf_pin_model (.core_clk, .ext_count_pin,
		.ext_int_pin, .port_upper_pins, .cmp_out);
	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	// Random watchdog ticks keep the shared prescaler busy
	always @(posedge core_clk) wdt_tick <= ($urandom % 8) == 0;
	// Tally watchdog ticks in and prescaled ticks out
	always @(posedge core_clk) begin
		wt += int'(wdt_tick === 1'h1);
		wp += int'(wdt_prescaled === 1'h1);
	end
	// ****************************************
	// Bus tasks and checks
	// ****************************************
	task automatic wr(input logic [7:0] a, d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask
	task automatic w(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] g, e);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e);
	endtask
	// Option value: int edge, source, count edge, assign, ratio
	function automatic logic [7:0] opt(input logic g, s, c, p,
		input logic [2:0] r);
		return {1'h0, g, s, c, p, r};
	endfunction
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Run needs about 5000 cycles; 30000 means a hang
	initial begin
		#300000;
		err_count++;
		close_out();
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		void'($urandom(66));
		resetn = 1'h0;
		por_event = 1'h1;
		sleep_mode = 1'h0;
		port_read = 1'h0;
		wdt_tick = 1'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (3) @(posedge core_clk);
		resetn <= 1'h1;
		rc(TMF_ADDR_INTCTL, 8'h00);
		rc(TMF_ADDR_OPTION, TMF_OPTION_RST);
		rc(TMF_ADDR_PFLAG, 8'h00);
		rc(TMF_ADDR_PEN, 8'h00);
		rc(8'h55, 8'h00);
		$display("reset test done");
		// Two held cycles after a write, then one count per cycle
		wr(TMF_ADDR_OPTION, opt(1'h0, 1'h0, 1'h0, 1'h1, 3'h0));
		v = 8'h10 + 8'($urandom % 8'he0);
		wr(TMF_ADDR_TIMER, v);
		rc(TMF_ADDR_TIMER, v);
		rc(TMF_ADDR_TIMER, v + 8'h01);
		rc(TMF_ADDR_TIMER, v + 8'h03);
		wr(TMF_ADDR_INTCTL, 8'h00);
		wr(TMF_ADDR_TIMER, 8'hfd);
		w(10);
		rc(TMF_ADDR_INTCTL, 8'h04);
		chk({7'h0, int_request}, 8'h00);
		wr(TMF_ADDR_INTCTL, 8'ha4);
		w(2);
		chk({7'h0, int_request}, 8'h01);
		wr(TMF_ADDR_INTCTL, 8'ha0);
		w(2);
		chk({7'h0, int_request}, 8'h00);
		$display("timer test done");
		// Asleep near the top: no count, so no overflow either
		wr(TMF_ADDR_TIMER, 8'hf8);
		sleep_mode <= 1'h1;
		rd(TMF_ADDR_TIMER, t0);
		wt0 = wt;
		wp0 = wp;
		w(300);
		n = 2 * (wp - wp0) - (wt - wt0);
		chk(8'(n >= -2 && n <= 2), 8'h01);
		rc(TMF_ADDR_TIMER, t0);
		rc(TMF_ADDR_INTCTL, 8'ha0);
		chk({7'h0, wake_request}, 8'h00);
		sleep_mode <= 1'h0;
		$display("sleep test done");
		// Every ratio over eight prescaled ticks; phase allows one off
		for (int s = 0; s < 8; s++) begin
			wr(TMF_ADDR_OPTION, opt(1'h0, 1'h0, 1'h0, 1'h0, 3'(s)));
			rd(TMF_ADDR_TIMER, t0);
			w((16 << s) - 2);
			rd(TMF_ADDR_TIMER, v);
			n = int'(8'(v - t0));
			chk(8'(n >= 7 && n <= 9), 8'h01);
		end
		$display("prescale test done");
		// Pulses end on a rising edge, so rising mode counts one more
		for (int e = 1; e >= 0; e--) begin
			wr(TMF_ADDR_OPTION, opt(1'h0, 1'h1, e[0], 1'h1, 3'h0));
			rd(TMF_ADDR_TIMER, t0);
			n = 3 + $urandom % 6;
			i_tmf_pin_model.pulse(n);
			rd(TMF_ADDR_TIMER, v);
			chk(v - t0, 8'(n + (e == 0)));
		end
		$display("counter test done");
		// Wrong edge first, then the selected one, while asleep
		sleep_mode <= 1'h1;
		for (int e = 0; e < 2; e++) begin
			wr(TMF_ADDR_OPTION, opt(e[0], 1'h1, 1'h0, 1'h1, 3'h0));
			i_tmf_pin_model.set_int(e[0]);
			wr(TMF_ADDR_INTCTL, 8'h10);
			i_tmf_pin_model.set_int(!e[0]);
			rc(TMF_ADDR_INTCTL, 8'h10);
			i_tmf_pin_model.set_int(e[0]);
			rc(TMF_ADDR_INTCTL, 8'h12);
			chk({7'h0, wake_request}, 8'h01);
			wr(TMF_ADDR_INTCTL, 8'h02);
			w(2);
			chk({7'h0, wake_request}, 8'h00);
		end
		sleep_mode <= 1'h0;
		$display("external test done");
		// Port change after a port read refreshed the latch
		wr(TMF_ADDR_INTCTL, 8'h08);
		port_read <= 1'h1;
		@(posedge core_clk);
		port_read <= 1'h0;
		rc(TMF_ADDR_INTCTL, 8'h08);
		i_tmf_pin_model.set_port(4'($urandom % 15 + 1));
		rc(TMF_ADDR_INTCTL, 8'h09);
		chk({7'h0, int_request}, 8'h00);
		wr(TMF_ADDR_INTCTL, 8'h89);
		w(2);
		chk({7'h0, int_request}, 8'h01);
		$display("port test done");
		// Comparator needs the peripheral enable as well
		wr(TMF_ADDR_PEN, 8'hff);
		rc(TMF_ADDR_PEN, 8'h40);
		wr(TMF_ADDR_INTCTL, 8'h80);
		i_tmf_pin_model.set_cmp(2'($urandom % 3 + 1));
		rc(TMF_ADDR_PFLAG, 8'h40);
		chk({7'h0, int_request}, 8'h00);
		wr(TMF_ADDR_INTCTL, 8'hc0);
		w(2);
		chk({7'h0, int_request}, 8'h01);
		$display("comparator test done");
		// Warm reset with everything set
		wr(TMF_ADDR_INTCTL, 8'hff);
		por_event <= 1'h0;
		@(posedge core_clk);
		resetn <= 1'h0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'h1;
		rd(TMF_ADDR_INTCTL, v);
		chk(v, 8'h01);
		$display("warm reset test done");
		close_out();
	end
endmodule

// ===== verif/tmf_pin_model.sv
`timescale 1ns/1ns
// ****************************************
// Pin side: count, interrupt, port, comparator
// ****************************************
module tmf_pin_model (
	input wire logic core_clk,
	output logic ext_count_pin,
	output logic ext_int_pin,
	output logic [3:0] port_upper_pins,
	output logic [1:0] cmp_out
);
	// Push-pull pins, so there is no released state to model
	initial begin
		ext_count_pin = 1'h0;
		ext_int_pin = 1'h0;
		port_upper_pins = 4'h0;
		cmp_out = 2'h0;
	end
	// Eight cycles outlast the three-flop synchroniser
	task automatic hold(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Low first, n pulses, then a rising edge left standing
	task automatic pulse(input int n);
		int w;
		ext_count_pin <= 1'h0;
		hold(8);
		for (int i = 0; i < n; i++) begin
			w = 4 + $urandom % 5; // Prompt and slow widths
			ext_count_pin <= 1'h1;
			hold(w);
			ext_count_pin <= 1'h0;
			hold(w);
		end
		ext_count_pin <= 1'h1;
		hold(8);
	endtask
	// Level changes on the interrupt-side pins
	task automatic set_int(input logic b);
		ext_int_pin <= b;
		hold(8);
	endtask
	task automatic set_port(input logic [3:0] p);
		port_upper_pins <= p;
		hold(8);
	endtask
	task automatic set_cmp(input logic [1:0] c);
		cmp_out <= c;
		hold(8);
	endtask
endmodule
